// *** vdma_pkg.sv ***
/*
  Shared constants and types for the dual-panel video DMA block.
  Assumes a 32-bit APB slave port and a quad-word memory read port.
*/
`default_nettype none
package vdma_pkg;
  // Register byte offsets
  localparam logic [11:0] VDMA_CTRL_OFS = 12'h01E0;
  localparam logic [11:0] VDMA_FB_START_OFS = 12'h01C0;
  localparam logic [11:0] VDMA_FB_END_OFS = 12'h01C4;
  localparam logic [11:0] VDMA_UP_INIT_OFS = 12'h01C8;
  localparam logic [11:0] VDMA_LO_INIT_OFS = 12'h01CC;
  localparam logic [11:0] VDMA_CUR_VSTART_OFS = 12'h01D0;
  localparam logic [11:0] VDMA_CUR_VEND_OFS = 12'h01D4;
  localparam logic [11:0] VDMA_DISP_VSTART_OFS = 12'h01D8;
  localparam logic [11:0] VDMA_DISP_VEND_OFS = 12'h01DC;
  localparam logic [11:0] VDMA_UP_PTR_OFS = 12'h01E4;
  localparam logic [11:0] VDMA_LO_PTR_OFS = 12'h01E8;
  localparam logic [11:0] VDMA_STATUS_OFS = 12'h01EC;
  // Control fields
  localparam int VDMA_CTRL_DUPLEX_BIT = 7;
  localparam int VDMA_CTRL_ENABLE_BIT = 5;
  localparam logic [7:0] VDMA_CTRL_RESET = 8'h00;
  // Pointer fields
  localparam int VDMA_LAST_BIT = 30;
  localparam logic [31:0] VDMA_ADDR_MASK = 32'hBFFF_FFF0;
  localparam logic [31:0] VDMA_QWORD_STEP = 32'h0000_0010;
  // Cursor vertical fields
  localparam int VDMA_SPLIT_HI = 14;
  localparam int VDMA_SPLIT_LO = 13;
  localparam int VDMA_RASTER_W = 13;
  localparam logic [31:0] VDMA_ZERO32 = 32'h0000_0000;
  localparam logic [1:0] VDMA_PEND_MAX = 2'h3;
  localparam logic [1:0] VDMA_PEND_ONE = 2'h1;

  typedef enum logic [1:0] {
    VDMA_SPLIT_OFF = 2'b00,
    VDMA_SPLIT_UPPER = 2'b01,
    VDMA_SPLIT_LOWER = 2'b10,
    VDMA_SPLIT_STRADDLE = 2'b11
  } vdma_split_e;

  // One memory read of a quad-word
  typedef struct packed {
    logic [31:0] addr;
    logic lower;
  } vdma_fetch_s;

  // Cursor enables per panel
  typedef struct packed {
    logic upper_on;
    logic lower_on;
  } vdma_cursor_s;
endpackage
`default_nettype wire

// *** vdma_dual_panel.sv ***
/*
  Dual-panel video DMA sequencer: APB register file, quad-word fetch
  sequencing across two panel pointers, and split cursor window decode.
  Assumes the video macrocell pulses vid_req once per wanted quad-word,
  and memory answers each mem_req with one mem_ack cycle carrying data.
*/
// Decided for this implementation: register access over APB.
// Notes on behaviour
// - Duplex fetches alternate: upper panel first, then the lower panel at its own pointer.
// - Block does the panel interleave so frame buffer is single-panel layout.
// - Cursor start bits 14:13: 00 and 01 upper, 10 lower, 11 straddling.
// - Cursor in one half: start and end count rasters from vsync.
// - Straddling: start counts in lower panel, end counts in upper panel.
// - Straddle shows lower from display start to cursor start, upper end to display end.
// - Duplex requests arrive as back-to-back pairs; an open pair is flagged.
// - Control register at 0x1E0: bit 7 duplex, bit 5 enable.
// - Each duplex pair fetches two quad-words, one at each panel pointer's own position.
// - Only the panel pointer just fetched advances by 0x10, or wraps to buffer start at the end.
`timescale 1ns/1ps
`default_nettype none
module vdma_dual_panel
  import vdma_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_sync,
  input wire logic vid_req,
  input wire logic [VDMA_RASTER_W-1:0] raster,
  output vdma_fetch_s mem_req_info,
  output logic mem_req,
  input wire logic mem_ack,
  input wire logic [127:0] mem_rdata,
  output logic [127:0] vid_data,
  output logic vid_valid,
  output logic vid_lower,
  output vdma_cursor_s cursor_on
);

  typedef enum logic [1:0] {
    VDMA_IDLE,
    VDMA_WAIT
  } vdma_state_e;

  logic [7:0] ctrl_r;
  logic [31:0] fb_start_r, fb_end_r, up_init_r, lo_init_r;
  logic [15:0] cur_vstart_r, cur_vend_r, disp_vstart_r, disp_vend_r;
  logic [31:0] up_ptr_r, lo_ptr_r;
  logic up_last_r, lo_last_r;
  logic panel_lower_r, pair_open_r, en_d_r;
  logic [1:0] pend_r;
  vdma_state_e state_r;
  logic [31:0] prdata_r, rd_val;
  logic pready_r, pslverr_r, hit;
  logic acc, wr_en, reload, start_fetch, done_fetch, wrap;
  logic duplex, enable;
  logic [31:0] cur_ptr, nxt_ptr;

  assign duplex = ctrl_r[VDMA_CTRL_DUPLEX_BIT];
  assign enable = ctrl_r[VDMA_CTRL_ENABLE_BIT];

  // Read mux and decode; unmapped offsets answer with an error
  always_comb begin
    hit = 1'b1;
    rd_val = VDMA_ZERO32;
    case (paddr[11:0])
      VDMA_CTRL_OFS: rd_val = {24'h00_0000, ctrl_r};
      VDMA_FB_START_OFS: rd_val = fb_start_r;
      VDMA_FB_END_OFS: rd_val = fb_end_r;
      VDMA_UP_INIT_OFS: rd_val = up_init_r;
      VDMA_LO_INIT_OFS: rd_val = lo_init_r;
      VDMA_CUR_VSTART_OFS: rd_val = {16'h0000, cur_vstart_r};
      VDMA_CUR_VEND_OFS: rd_val = {16'h0000, cur_vend_r};
      VDMA_DISP_VSTART_OFS: rd_val = {16'h0000, disp_vstart_r};
      VDMA_DISP_VEND_OFS: rd_val = {16'h0000, disp_vend_r};
      VDMA_UP_PTR_OFS: rd_val = up_ptr_r;
      VDMA_LO_PTR_OFS: rd_val = lo_ptr_r;
      VDMA_STATUS_OFS: rd_val = {28'h000_0000, pair_open_r, panel_lower_r, pend_r != 2'h0,
                                 state_r == VDMA_WAIT};
      default: hit = 1'b0;
    endcase
    if (paddr[31:12] != 20'h0_0000) begin
      hit = 1'b0;
      rd_val = VDMA_ZERO32;
    end
  end

  // One wait state so read data and ready come straight from flops
  assign acc = psel & penable;
  assign wr_en = acc & pready_r & pwrite & ~pslverr_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= VDMA_ZERO32;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~hit;
      if (acc & ~pready_r & ~pwrite) begin
        prdata_r <= rd_val;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= VDMA_CTRL_RESET;
      fb_start_r <= VDMA_ZERO32;
      fb_end_r <= VDMA_ZERO32;
      up_init_r <= VDMA_ZERO32;
      lo_init_r <= VDMA_ZERO32;
      cur_vstart_r <= 16'h0000;
      cur_vend_r <= 16'h0000;
      disp_vstart_r <= 16'h0000;
      disp_vend_r <= 16'h0000;
    end else if (wr_en) begin
      case (paddr[11:0])
        VDMA_CTRL_OFS: ctrl_r <= pwdata[7:0];
        VDMA_FB_START_OFS: fb_start_r <= pwdata & VDMA_ADDR_MASK;
        VDMA_FB_END_OFS: fb_end_r <= pwdata & VDMA_ADDR_MASK;
        VDMA_UP_INIT_OFS: up_init_r <= pwdata;
        VDMA_LO_INIT_OFS: lo_init_r <= pwdata;
        VDMA_CUR_VSTART_OFS: cur_vstart_r <= pwdata[15:0];
        VDMA_CUR_VEND_OFS: cur_vend_r <= pwdata[15:0];
        VDMA_DISP_VSTART_OFS: disp_vstart_r <= pwdata[15:0];
        VDMA_DISP_VEND_OFS: disp_vend_r <= pwdata[15:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Pointers reload at each frame and on enable rising
  assign reload = frame_sync | (enable & ~en_d_r);
  assign start_fetch = (state_r == VDMA_IDLE) & enable & (pend_r != 2'h0) & ~reload;
  assign done_fetch = (state_r == VDMA_WAIT) & mem_ack;
  assign cur_ptr = panel_lower_r ? lo_ptr_r : up_ptr_r;
  // Last flag forces the wrap even before the end compare would
  assign wrap = (cur_ptr == fb_end_r) | (panel_lower_r ? lo_last_r : up_last_r);
  assign nxt_ptr = wrap ? fb_start_r : cur_ptr + VDMA_QWORD_STEP;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= enable;
    end
  end

  // Panel pointers; only the panel just fetched moves
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_ptr_r <= VDMA_ZERO32;
      lo_ptr_r <= VDMA_ZERO32;
      up_last_r <= 1'b0;
      lo_last_r <= 1'b0;
    end else if (reload) begin
      up_ptr_r <= up_init_r & VDMA_ADDR_MASK;
      lo_ptr_r <= lo_init_r & VDMA_ADDR_MASK;
      up_last_r <= up_init_r[VDMA_LAST_BIT];
      lo_last_r <= lo_init_r[VDMA_LAST_BIT];
    end else if (done_fetch) begin
      if (panel_lower_r) begin
        lo_ptr_r <= nxt_ptr;
        lo_last_r <= 1'b0;
      end else begin
        up_ptr_r <= nxt_ptr;
        up_last_r <= 1'b0;
      end
    end
  end

  // Panel select: upper first, alternate only in duplex
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      panel_lower_r <= 1'b0;
    end else if (reload || !duplex) begin
      panel_lower_r <= 1'b0;
    end else if (done_fetch) begin
      panel_lower_r <= ~panel_lower_r;
    end
  end

  // Pending requests; a request in the same cycle as a start is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 2'h0;
    end else if (reload) begin
      pend_r <= {1'b0, vid_req};
    end else if (vid_req && !start_fetch && pend_r != VDMA_PEND_MAX) begin
      pend_r <= pend_r + VDMA_PEND_ONE;
    end else if (!vid_req && start_fetch) begin
      pend_r <= pend_r - VDMA_PEND_ONE;
    end
  end

  // Pair tracking: first of a duplex pair opens, second closes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pair_open_r <= 1'b0;
    end else if (reload || !duplex) begin
      pair_open_r <= 1'b0;
    end else if (vid_req) begin
      pair_open_r <= ~pair_open_r;
    end
  end

  // Fetch sequencer; request held until memory acknowledges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= VDMA_IDLE;
      mem_req <= 1'b0;
      mem_req_info <= '0;
    end else begin
      case (state_r)
        VDMA_IDLE: begin
          if (start_fetch) begin
            state_r <= VDMA_WAIT;
            mem_req <= 1'b1;
            mem_req_info.addr <= cur_ptr;
            mem_req_info.lower <= panel_lower_r;
          end
        end
        VDMA_WAIT: begin
          if (mem_ack) begin
            state_r <= VDMA_IDLE;
            mem_req <= 1'b0;
          end
        end
        default: begin
          state_r <= VDMA_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // Hand fetched data to the macrocell tagged with its panel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vid_data <= 128'h0;
      vid_valid <= 1'b0;
      vid_lower <= 1'b0;
    end else begin
      vid_valid <= done_fetch;
      if (done_fetch) begin
        vid_data <= mem_rdata;
        vid_lower <= panel_lower_r;
      end
    end
  end

  // Cursor windows; straddle swaps meaning of start and end
  logic [VDMA_RASTER_W-1:0] cs, ce, ds, de;
  vdma_split_e split;
  logic in_norm, in_lo_str, in_up_str;
  assign cs = cur_vstart_r[VDMA_RASTER_W-1:0];
  assign ce = cur_vend_r[VDMA_RASTER_W-1:0];
  assign ds = disp_vstart_r[VDMA_RASTER_W-1:0];
  assign de = disp_vend_r[VDMA_RASTER_W-1:0];
  assign split = vdma_split_e'(cur_vstart_r[VDMA_SPLIT_HI:VDMA_SPLIT_LO]);
  assign in_norm = (raster >= cs) && (raster < ce);
  assign in_lo_str = (raster >= ds) && (raster < cs);
  assign in_up_str = (raster >= ce) && (raster < de);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cursor_on <= '0;
    end else begin
      case (split)
        VDMA_SPLIT_OFF: cursor_on <= {in_norm, 1'b0};
        VDMA_SPLIT_UPPER: cursor_on <= {in_norm, 1'b0};
        VDMA_SPLIT_LOWER: cursor_on <= {1'b0, in_norm};
        VDMA_SPLIT_STRADDLE: cursor_on <= {in_up_str, in_lo_str};
        default: cursor_on <= '0;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Checks
  step_upper_a: assert property (@(posedge clk) disable iff (!resetn)
    (done_fetch && !panel_lower_r && !reload && !up_last_r && up_ptr_r != fb_end_r)
      |=> (up_ptr_r == $past(up_ptr_r) + VDMA_QWORD_STEP))
    else $error("upper pointer did not step by one quad-word");
  step_lower_a: assert property (@(posedge clk) disable iff (!resetn)
    (done_fetch && panel_lower_r && !reload && !lo_last_r && lo_ptr_r != fb_end_r)
      |=> (lo_ptr_r == $past(lo_ptr_r) + VDMA_QWORD_STEP))
    else $error("lower pointer did not step by one quad-word");
  wrap_end_a: assert property (@(posedge clk) disable iff (!resetn)
    (done_fetch && !reload && (up_last_r || up_ptr_r == fb_end_r) && !panel_lower_r)
      |=> (up_ptr_r == fb_start_r))
    else $error("pointer did not wrap to buffer start");
  panel_alt_a: assert property (@(posedge clk) disable iff (!resetn)
    (done_fetch && duplex && !reload) ##1 (duplex && !reload) |-> (panel_lower_r != $past(panel_lower_r)))
    else $error("duplex panel did not alternate");
  single_upper_a: assert property (@(posedge clk) disable iff (!resetn)
    (start_fetch && !duplex && !$past(duplex)) |=> !mem_req_info.lower)
    else $error("single panel fetched from lower pointer");
  tag_match_a: assert property (@(posedge clk) disable iff (!resetn)
    (start_fetch) |=> (mem_req && mem_req_info.addr == $past(cur_ptr)))
    else $error("fetch address not taken from the panel pointer");
  data_deliver_a: assert property (@(posedge clk) disable iff (!resetn)
    (done_fetch) |=> (vid_valid && vid_data == $past(mem_rdata) && vid_lower == $past(panel_lower_r)))
    else $error("fetched data not delivered with its panel");
  straddle_cur_a: assert property (@(posedge clk) disable iff (!resetn)
    (split == VDMA_SPLIT_STRADDLE && raster >= ds && raster < cs) |=> cursor_on.lower_on)
    else $error("straddled cursor missing in lower half");
  ctrl_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr_en && paddr[11:0] == VDMA_CTRL_OFS) |=> (ctrl_r == $past(pwdata[7:0])))
    else $error("control register write lost");
  pair_close_a: assert property (@(posedge clk) disable iff (!resetn)
    (vid_req && pair_open_r && duplex && !reload) |=> !pair_open_r)
    else $error("request pair left open");
  fetch_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (!enable && state_r == VDMA_IDLE) |=> !mem_req)
    else $error("fetch started while disabled");
  apb_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    (psel && penable && !pready) |=> pready)
    else $error("slave answer late");

endmodule // vdma_dual_panel
`default_nettype wire

// *** vdma_macro_model.sv ***
/*
  Model of the video macrocell and memory port that face the dual-panel video DMA.
  Assumes one clock; every output changes only just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module vdma_macro_model
  import vdma_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pair_go,
  input wire logic [3:0] ack_wait,
  input wire logic mem_req,
  input wire vdma_fetch_s mem_req_info,
  output logic vid_req,
  output logic mem_ack,
  output logic [127:0] mem_rdata
);
  logic [1:0] left_r;
  logic [3:0] wait_r;

  // Macrocell set for LCD drive and duplex panels, so requests leave as two adjacent pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_r <= 2'h0;
    end else if (pair_go) begin
      left_r <= 2'h2;
    end else if (left_r != 2'h0) begin
      left_r <= left_r - 2'h1;
    end
  end
  assign vid_req = (left_r != 2'h0);

  // Memory answers after ack_wait cycles; data carries the address so fetches can be told apart
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= '0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack && wait_r == ack_wait) begin
        mem_ack <= 1'b1;
        mem_rdata <= {4{mem_req_info.addr}};
        wait_r <= 4'h0;
      end else begin
        mem_rdata <= ~mem_rdata; // Stale data must never look like a valid answer
        if (mem_req && !mem_ack) begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule // vdma_macro_model
`default_nettype wire

// *** vdma_dual_panel_tb_top.sv ***
/*
  Self-checking bench for the dual-panel video DMA: registers over APB, fetch order, cursor windows.
  Assumes the macrocell model answers fetches and the design keeps its one-wait-state APB answer.
*/
`timescale 1ns/1ps
`default_nettype none
module vdma_dual_panel_tb_top;
  import vdma_pkg::*;
  localparam logic [31:0] FB_S = 32'h0000_1000;
  localparam logic [31:0] FB_E = 32'h0000_10F0;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic pready, pslverr, frame_sync = 1'b0, vid_req, mem_req, mem_ack, vid_valid, vid_lower, pair_go = 1'b0;
  logic [12:0] raster = '0;
  logic [3:0] ack_wait = 4'h0;
  logic [127:0] mem_rdata, vid_data;
  vdma_fetch_s mem_req_info;
  vdma_cursor_s cursor_on;
  logic [32:0] got[$], req[$];
  int errors = 0, samples_checked = 0, cycles = 0;
  logic [31:0] rd;
  logic err;

  always #50 clk = ~clk;
  vdma_dual_panel i_vdma_dual_panel (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync(frame_sync), .vid_req(vid_req), .raster(raster), .mem_req_info(mem_req_info),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .vid_data(vid_data),
    .vid_valid(vid_valid), .vid_lower(vid_lower), .cursor_on(cursor_on));
  vdma_macro_model i_vdma_macro_model (.clk(clk), .resetn(resetn), .pair_go(pair_go), .ack_wait(ack_wait),
    .mem_req(mem_req), .mem_req_info(mem_req_info), .vid_req(vid_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // Collect each delivered quad-word: panel flag and address carried in its data
  always @(posedge clk) begin
    cycles++;
    if (vid_valid === 1'b1) got.push_back({vid_lower, vid_data[31:0]});
    if (mem_ack === 1'b1) req.push_back({mem_req_info.lower, mem_req_info.addr});
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Set up buffer and panel pointers, choose mode, reload at a frame edge
  task automatic setup(input logic [31:0] up, input logic [31:0] lo, input logic [7:0] ctl);
    apb(1'b1, {20'h0_0000, VDMA_FB_START_OFS}, FB_S);
    apb(1'b1, {20'h0_0000, VDMA_FB_END_OFS}, FB_E);
    apb(1'b1, {20'h0_0000, VDMA_UP_INIT_OFS}, up);
    apb(1'b1, {20'h0_0000, VDMA_LO_INIT_OFS}, lo);
    apb(1'b1, {20'h0_0000, VDMA_CTRL_OFS}, {24'h00_0000, ctl});
    @(posedge clk) frame_sync <= 1'b1;
    @(posedge clk) frame_sync <= 1'b0;
    got.delete();
    req.delete();
  endtask

  // Ask for n pairs, then compare every fetch with the expected panel and address
  task automatic run_pairs(input int n, input logic duplex, input logic [31:0] up, input logic [31:0] lo);
    logic [31:0] p[2];
    p[0] = up;
    p[1] = lo;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) pair_go <= 1'b1;
      @(posedge clk) pair_go <= 1'b0;
      for (int k = 0; k < 200 && got.size() < 2 * (i + 1); k++) @(posedge clk);
    end
    chk("fetch count", 2 * n, got.size());
    for (int j = 0; j < got.size(); j++) begin
      logic s;
      s = duplex & j[0];
      chk("fetch", {s, p[s]}, got[j]);
      chk("request", {s, p[s]}, req[j]);
      p[s] = (p[s] == FB_E) ? FB_S : p[s] + 32'h0000_0010;
    end
  endtask

  task automatic reg_test();
    apb(1'b0, {20'h0_0000, VDMA_CTRL_OFS}, 32'h0);
    chk("control reset", VDMA_CTRL_RESET, rd);
    apb(1'b1, {20'h0_0000, VDMA_CTRL_OFS}, 32'h0000_00A5);
    apb(1'b0, {20'h0_0000, VDMA_CTRL_OFS}, 32'h0);
    chk("control readback", 32'h0000_00A5, rd);
    apb(1'b0, 32'h0000_01F0, 32'h0);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic cursor_test();
    logic [1:0] md[9] = '{2'b01, 2'b01, 2'b01, 2'b10, 2'b10, 2'b11, 2'b11, 2'b11, 2'b00};
    logic [12:0] rs[9] = '{13'h14, 13'h28, 13'h13, 13'h1E, 13'h32, 13'h0A, 13'h32, 13'h1E, 13'h1E};
    logic [1:0] ex[9] = '{2'b10, 2'b00, 2'b00, 2'b01, 2'b00, 2'b01, 2'b10, 2'b00, 2'b10};
    apb(1'b1, {20'h0_0000, VDMA_CUR_VEND_OFS}, 32'h0000_0028);
    apb(1'b1, {20'h0_0000, VDMA_DISP_VSTART_OFS}, 32'h0000_0005);
    apb(1'b1, {20'h0_0000, VDMA_DISP_VEND_OFS}, 32'h0000_003C);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, {20'h0_0000, VDMA_CUR_VSTART_OFS}, {17'h0_0000, md[i], 13'h0014});
      @(posedge clk) raster <= rs[i];
      repeat (3) @(posedge clk);
      chk("cursor", ex[i], cursor_on);
    end
  endtask

  task automatic disabled_test();
    setup(FB_S, FB_S + 32'h0000_0080, 8'h80);
    @(posedge clk) pair_go <= 1'b1;
    @(posedge clk) pair_go <= 1'b0;
    repeat (30) @(posedge clk);
    chk("no fetch when off", 1'b0, mem_req);
    chk("no data when off", 0, got.size());
    apb(1'b0, {20'h0_0000, VDMA_STATUS_OFS}, 32'h0);
    chk("status", 32'h0000_0002, rd);
    apb(1'b0, {20'h0_0000, VDMA_UP_PTR_OFS}, 32'h0);
    chk("upper pointer", FB_S, rd);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    reg_test();
    ack_wait <= 4'h3;
    setup(FB_S + 32'h0000_0080, FB_S, 8'hA0);
    run_pairs(10, 1'b1, FB_S + 32'h0000_0080, FB_S);
    ack_wait <= 4'h0;
    setup(FB_S + 32'h0000_0080, FB_S, 8'h20);
    run_pairs(2, 1'b0, FB_S + 32'h0000_0080, FB_S);
    setup(FB_E | 32'h4000_0000, FB_S + 32'h0000_0070, 8'hA0);
    run_pairs(2, 1'b1, FB_E, FB_S + 32'h0000_0070);
    cursor_test();
    disabled_test();
    test_done();
  end
endmodule // vdma_dual_panel_tb_top
`default_nettype wire
